// *** hw/intc_pkg.sv ***
// Constants and carrier types shared by the interrupt controller.
package intc_pkg;

    // ****************************************
    // Register word addresses on the bus
    // ****************************************
    localparam logic [3:0] ADR_RESET_CTRL = 4'h0;
    localparam logic [3:0] ADR_INT_CTRL = 4'h1;
    localparam logic [3:0] ADR_INT_CTRL_2 = 4'h2;
    localparam logic [3:0] ADR_INT_CTRL_3 = 4'h3;
    localparam logic [3:0] ADR_FLAG_1 = 4'h4;
    localparam logic [3:0] ADR_FLAG_3 = 4'h6;
    localparam logic [3:0] ADR_ENABLE_1 = 4'h7;
    localparam logic [3:0] ADR_ENABLE_3 = 4'h9;
    localparam logic [3:0] ADR_PRIO_1 = 4'hA;
    localparam logic [3:0] ADR_PRIO_3 = 4'hC;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PRIO_EN_BIT = 7;
    localparam int GHIGH_BIT = 7;
    localparam int GLOW_BIT = 6;
    localparam int TMR0_EN_BIT = 5;
    localparam int EXT0_EN_BIT = 4;
    localparam int PORT_EN_BIT = 3;
    localparam int TMR0_FLAG_BIT = 2;
    localparam int EXT0_FLAG_BIT = 1;
    localparam int PORT_FLAG_BIT = 0;
    localparam int EDGE0_BIT = 6;
    localparam int TMR0_PRIO_BIT = 2;
    localparam int EXT3_PRIO_BIT = 1;
    localparam int PORT_PRIO_BIT = 0;
    localparam int EXT2_PRIO_BIT = 7;
    localparam int EXT1_PRIO_BIT = 6;
    localparam int EXT1_EN_BIT = 3;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_INT_CTRL_2 = 8'hFF;
    localparam logic [7:0] RST_INT_CTRL_3 = 8'hC0;

    // ****************************************
    // Vectors and timing
    // ****************************************
    localparam logic [15:0] VEC_HIGH = 16'h0008;
    localparam logic [15:0] VEC_LOW = 16'h0018;
    localparam logic [1:0] CYC_PER_INSTR_M1 = 2'h3;

    // Controller sequence, one-hot.
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_ARMED = 3'b010,
        ST_VECT = 3'b100
    } seq_e;

    // Vector request to the core.
    typedef struct packed {
        logic take;
        logic high;
        logic [15:0] addr;
    } core_vec_s;

    // Avalon-MM slave request.
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avm_req_s;

    // Controller state, all but wake_req.
    typedef struct packed {
        seq_e seq;
        logic [1:0] div;
        logic prio_en;
        logic [7:0] ictl;
        logic [7:0] ictl2;
        logic [7:0] ictl3;
        logic [23:0] pflag;
        logic [23:0] pen;
        logic [23:0] ppri;
        logic hi_act;
        logic lo_act;
        logic [7:0] sy1;
        logic [7:0] sy2;
        logic [7:0] sy3;
        logic [7:0] lvl;
        logic ack;
        logic [7:0] rdata;
        core_vec_s vec;
    } st_s;

endpackage

// *** hw/two_level_interrupt_controller.sv ***
// Two-level interrupt controller with an Avalon-MM register port.
//
// Summary of operation
// - High goes to 0008h, low to 0018h.
// - Pending high request preempts low service.
// - Thirteen registers including nine peripheral ones.
// - Each source has flag, enable, priority; pin 0 has no priority bit and is always high.
// - Priorities only when priority_enable set.
// - global_high_enable admits high-priority sources.
// - Low sources need both global enables.
// - Flag, enable, globals set: vector immediately.
// - priority_enable clear means compatibility mode.
// - Compatibility: bit 6 peripherals, bit 7 all.
// - Compatibility mode always vectors to 0008h.
// - Taking interrupt clears the matching global enable.
// - No low service during high service.
// - Core pushes return address, loads vector.
// - Return instruction sets the cleared global enable.
// - Pin interrupts take three to four cycles.
// - Flags set regardless of any enable.
// - Flags stay set until software clears.
// - Edge select: one rising, zero falling.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module two_level_interrupt_controller
    import intc_pkg::*;
(
    input wire logic sys_clk, // 20 MHz clock.
    input wire logic reset_n, // Synchronous reset, low.
    input wire intc_pkg::avm_req_s avm, // Bus request.
    output logic waitrequest, // Bus stall.
    output logic [31:0] readdata, // Bus read data.
    input wire logic [3:0] ext_pin, // External interrupt pins.
    input wire logic [3:0] port_pin, // Change-watched pins.
    input wire logic tmr0_overflow, // Timer 0 overflow pulse.
    input wire logic [23:0] periph_event, // Peripheral pulses.
    input wire logic return_from_interrupt_instr, // Return pulse.
    output intc_pkg::core_vec_s core_vec, // Vector to core.
    output logic wake_req // Leave idle or sleep.
);
    import intc_pkg::*;

    // ****************************************
    // State
    // ****************************************
    st_s st;
    st_s next_st;
    logic wake_req_next;

    // All controller state but wake_req lives in one packed record. The divider
    // makes the instruction tick, the three pin stages filter the
    // asynchronous pins, and lvl holds the last accepted pin level.
    // The two service marks record which level is in progress, so a
    // return knows which global enable to set again.
    // Keeping every bit but wake_req in one record means reset and the register
    // update are written once, at the cost of a wide next-state copy.

    // ****************************************
    // Bus handshake
    // ****************************************

    // One wait cycle on every access keeps read data registered.
    assign waitrequest = (avm.read | avm.write) & ~st.ack;
    assign readdata = {24'h000000, st.rdata};
    assign core_vec = st.vec;

    // ****************************************
    // Next state
    // ****************************************

    // All behaviour is worked out here on a copy of the state.
    always_comb
    begin
        logic tick;
        logic req;
        logic [7:0] edge_ok;
        logic [7:0] chg;
        logic [5:0] core_act;
        logic [5:0] core_pri;
        logic [23:0] per_act;
        logic [7:0] wv;
        logic hi_req;
        logic lo_req;
        logic ext_hit;
        tick = 1'b0;
        req = 1'b0;
        edge_ok = 8'h00;
        chg = 8'h00;
        core_act = 6'h00;
        core_pri = 6'h00;
        per_act = 24'h000000;
        wv = 8'h00;
        hi_req = 1'b0;
        lo_req = 1'b0;
        ext_hit = 1'b0;
        next_st = st;
        next_st.vec.take = 1'b0;

        // The instruction clock is a one-cycle enable every fourth
        // system clock.
        tick = (st.div == CYC_PER_INSTR_M1);
        next_st.div = tick ? 2'h0 : st.div + 2'h1;

        // Pins pass three flops; a level counts once the last two
        // agree, which filters a glitch shorter than one clock.
        next_st.sy1 = {port_pin, ext_pin};
        next_st.sy2 = st.sy1;
        next_st.sy3 = st.sy2;
        for (int i = 0; i < 8; i++)
        begin
            chg[i] = (st.sy2[i] == st.sy3[i]) &&
                (st.sy3[i] != st.lvl[i]);
            if (chg[i])
            begin
                next_st.lvl[i] = st.sy3[i];
            end
        end

        // Edge polarity per external pin.
        edge_ok[0] = st.sy3[0] == st.ictl2[EDGE0_BIT];
        edge_ok[1] = st.sy3[1] == st.ictl2[EDGE0_BIT - 1];
        edge_ok[2] = st.sy3[2] == st.ictl2[EDGE0_BIT - 2];
        edge_ok[3] = st.sy3[3] == st.ictl2[EDGE0_BIT - 3];

        // Bus: the access is answered one cycle after it appears.
        // Read data is latched on the first cycle, so it stands from
        // a register while waitrequest is low. A master that drops
        // its request early simply leaves the answer unused.
        req = avm.read | avm.write;
        next_st.ack = req & ~st.ack;
        if (req && !st.ack)
        begin
            case (avm.address)
                ADR_RESET_CTRL: next_st.rdata =
                    {st.prio_en, 7'h00};
                ADR_INT_CTRL: next_st.rdata = st.ictl;
                ADR_INT_CTRL_2: next_st.rdata = st.ictl2;
                ADR_INT_CTRL_3: next_st.rdata = st.ictl3;
                4'h4: next_st.rdata = st.pflag[7:0];
                4'h5: next_st.rdata = st.pflag[15:8];
                ADR_FLAG_3: next_st.rdata = st.pflag[23:16];
                ADR_ENABLE_1: next_st.rdata = st.pen[7:0];
                4'h8: next_st.rdata = st.pen[15:8];
                ADR_ENABLE_3: next_st.rdata = st.pen[23:16];
                ADR_PRIO_1: next_st.rdata = st.ppri[7:0];
                4'hB: next_st.rdata = st.ppri[15:8];
                ADR_PRIO_3: next_st.rdata = st.ppri[23:16];
                default: next_st.rdata = 8'h00;
            endcase
        end

        // The write lands on the cycle the master sees the answer.
        wv = avm.writedata[7:0];
        if (avm.write && st.ack && avm.byteenable[0])
        begin
            case (avm.address)
                ADR_RESET_CTRL: next_st.prio_en = wv[PRIO_EN_BIT];
                ADR_INT_CTRL: next_st.ictl = wv;
                ADR_INT_CTRL_2: next_st.ictl2 = wv;
                ADR_INT_CTRL_3: next_st.ictl3 = wv;
                4'h4: next_st.pflag[7:0] = wv;
                4'h5: next_st.pflag[15:8] = wv;
                ADR_FLAG_3: next_st.pflag[23:16] = wv;
                ADR_ENABLE_1: next_st.pen[7:0] = wv;
                4'h8: next_st.pen[15:8] = wv;
                ADR_ENABLE_3: next_st.pen[23:16] = wv;
                ADR_PRIO_1: next_st.ppri[7:0] = wv;
                4'hB: next_st.ppri[15:8] = wv;
                ADR_PRIO_3: next_st.ppri[23:16] = wv;
                default: next_st.ppri = next_st.ppri;
            endcase
        end

        // Events set flags after the write, so a set in the same
        // cycle as a software clear wins. Hardware never clears a
        // flag on its own.
        if (tmr0_overflow)
        begin
            next_st.ictl[TMR0_FLAG_BIT] = 1'b1;
        end
        if (chg[0] && edge_ok[0])
        begin
            next_st.ictl[EXT0_FLAG_BIT] = 1'b1;
        end
        for (int i = 1; i < 4; i++)
        begin
            if (chg[i] && edge_ok[i])
            begin
                next_st.ictl3[i - 1] = 1'b1;
            end
        end
        if (|chg[7:4])
        begin
            next_st.ictl[PORT_FLAG_BIT] = 1'b1;
        end
        next_st.pflag = next_st.pflag | periph_event;

        // Per-source request: flag and enable. Order is timer 0,
        // pin 0, pins 1 to 3, port change.
        core_act[0] = st.ictl[TMR0_FLAG_BIT] & st.ictl[TMR0_EN_BIT];
        core_act[1] = st.ictl[EXT0_FLAG_BIT] & st.ictl[EXT0_EN_BIT];
        core_act[2] = st.ictl3[0] & st.ictl3[EXT1_EN_BIT];
        core_act[3] = st.ictl3[1] & st.ictl3[EXT1_EN_BIT + 1];
        core_act[4] = st.ictl3[2] & st.ictl3[EXT1_EN_BIT + 2];
        core_act[5] = st.ictl[PORT_FLAG_BIT] & st.ictl[PORT_EN_BIT];
        per_act = st.pflag & st.pen;

        // Pin 0 has no priority bit and is always high.
        core_pri[0] = st.ictl2[TMR0_PRIO_BIT];
        core_pri[1] = 1'b1;
        core_pri[2] = st.ictl3[EXT1_PRIO_BIT];
        core_pri[3] = st.ictl3[EXT2_PRIO_BIT];
        core_pri[4] = st.ictl2[EXT3_PRIO_BIT];
        core_pri[5] = st.ictl2[PORT_PRIO_BIT];

        // Wake-up ignores the global enables.
        next_st.ictl = next_st.ictl;
        ext_hit = (|core_act) | (|per_act);

        if (st.prio_en)
        begin
            hi_req = st.ictl[GHIGH_BIT] &
                ((|(core_act & core_pri)) |
                 (|(per_act & st.ppri)));
            lo_req = st.ictl[GHIGH_BIT] & st.ictl[GLOW_BIT] &
                ~st.hi_act &
                ((|(core_act & ~core_pri)) |
                 (|(per_act & ~st.ppri)));
        end
        else
        begin
            // Priority bits play no part here.
            hi_req = st.ictl[GHIGH_BIT] & ((|core_act) |
                (st.ictl[GLOW_BIT] & (|per_act)));
            lo_req = 1'b0;
        end

        // Sequence: a request seen on one instruction tick is taken
        // on the next, giving a fixed latency whatever the core runs.
        // The level is chosen again at the second tick, so a high
        // request that arrives meanwhile wins over a low one.
        // Taking clears the matching global enable in the same cycle,
        // and that clear overrides a software write to the register.
        case (st.seq)
            ST_RUN:
            begin
                if (tick && (hi_req || lo_req))
                begin
                    next_st.seq = ST_ARMED;
                end
            end
            ST_ARMED:
            begin
                if (tick)
                begin
                    next_st.seq = ST_VECT;
                    if (hi_req)
                    begin
                        next_st.vec.take = 1'b1;
                        next_st.vec.high = 1'b1;
                        next_st.vec.addr = VEC_HIGH;
                        next_st.ictl[GHIGH_BIT] = 1'b0;
                        next_st.hi_act = 1'b1;
                    end
                    else if (lo_req)
                    begin
                        next_st.vec.take = 1'b1;
                        next_st.vec.high = 1'b0;
                        next_st.vec.addr = VEC_LOW;
                        next_st.ictl[GLOW_BIT] = 1'b0;
                        next_st.lo_act = 1'b1;
                    end
                    else
                    begin
                        // Request withdrawn before it was taken.
                        next_st.seq = ST_RUN;
                    end
                end
            end
            ST_VECT:
            begin
                next_st.seq = ST_RUN;
            end
            default:
            begin
                next_st.seq = ST_RUN;
            end
        endcase

        // Return sets again the enable the matching take cleared;
        // high service is unwound first since it nests inside low.
        // A return with no service marked sets the high enable, which
        // is also the only enable that a compatibility-mode take clears.
        if (return_from_interrupt_instr)
        begin
            if (st.hi_act || !st.lo_act)
            begin
                next_st.ictl[GHIGH_BIT] = 1'b1;
                next_st.hi_act = 1'b0;
            end
            else
            begin
                next_st.ictl[GLOW_BIT] = 1'b1;
                next_st.lo_act = 1'b0;
            end
        end

        // Reset clears every enable, priority mode and flags.
        if (!reset_n)
        begin
            next_st = '0;
            next_st.seq = ST_RUN;
            next_st.ictl = RST_ZERO;
            next_st.ictl2 = RST_INT_CTRL_2;
            next_st.ictl3 = RST_INT_CTRL_3;
            next_st.vec.addr = VEC_HIGH;
            ext_hit = 1'b0;
        end
        next_st.vec.high = next_st.vec.high;
        wake_req_next = ext_hit;
    end

    // ****************************************
    // Registers
    // ****************************************

    // The wake request is registered so it is a clean level.
    // Reset is handled in the next-state logic, so this process holds
    // nothing but the flip-flops themselves.
    always_ff @(posedge sys_clk)
    begin
        st <= next_st;
        wake_req <= wake_req_next;
    end

endmodule

`default_nettype wire

// *** verif/two_level_interrupt_controller_props.sv ***
// Port-level checker for the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module intc_props
    import intc_pkg::*;
(
    input wire logic sys_clk, // Clock.
    input wire logic reset_n, // Reset, low.
    input wire intc_pkg::avm_req_s avm, // Bus request.
    input wire logic waitrequest, // Bus stall.
    input wire logic [31:0] readdata, // Read data.
    input wire logic return_from_interrupt_instr, // Return pulse.
    input wire intc_pkg::core_vec_s core_vec, // Vector request.
    input wire logic wake_req // Wake-up request.
);
    // ****************************************
    // Helpers and sequences
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire logic req = avm.read || avm.write;
    logic hi_busy;
    // A return always ends a high service first, as high preempts low.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || return_from_interrupt_instr)
            hi_busy <= 1'b0;
        else if (core_vec.take && core_vec.high)
            hi_busy <= 1'b1;
    end
    sequence s_stall;
        req && waitrequest;
    endsequence
    sequence s_answer;
        req && !waitrequest;
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    chk_bus_one_wait: assert property (s_stall |=> s_answer)
        else $error("bus stall longer than one cycle");
    chk_bus_idle: assert property (!req |-> !waitrequest)
        else $error("stall without request");
    chk_unmapped_zero: assert property (s_answer |->
        (!avm.read || avm.address <= 4'hC || readdata == 32'h0))
        else $error("unmapped read not zero");
    chk_rdata_upper: assert property (s_answer |->
        readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_vec_addr: assert property (core_vec.take |->
        core_vec.addr == (core_vec.high ? VEC_HIGH : VEC_LOW))
        else $error("vector address wrong for level");
    chk_take_gap: assert property (core_vec.take |=>
        !core_vec.take [*3])
        else $error("take not on instruction tick");
    chk_vec_stands: assert property (!core_vec.take |->
        $stable(core_vec.addr) && $stable(core_vec.high))
        else $error("vector changed without take");
    chk_take_cause: assert property (core_vec.take |->
        $past(wake_req))
        else $error("take without pending request");
    chk_low_blocked: assert property (core_vec.take && hi_busy |->
        core_vec.high)
        else $error("low taken during high service");
endmodule
bind two_level_interrupt_controller intc_props i_intc_props(
    .sys_clk(sys_clk), .reset_n(reset_n), .avm(avm),
    .waitrequest(waitrequest), .readdata(readdata),
    .return_from_interrupt_instr(return_from_interrupt_instr),
    .core_vec(core_vec), .wake_req(wake_req));
`default_nettype wire

// *** verif/core_model.sv ***
// Behavioural processor core that takes vectors and returns.
`timescale 1ns/1ps
`default_nettype none
module core_model
    import intc_pkg::*;
(
    input wire logic sys_clk, // Clock.
    input wire logic reset_n, // Reset, low.
    input wire intc_pkg::core_vec_s core_vec, // Vector request.
    input wire logic ret_req, // Bench asks for a return.
    output logic ret_pulse, // Return instruction pulse.
    output logic [15:0] pc, // Program counter.
    output int depth // Handler nesting depth.
);
    logic [15:0] stk[$];
    // Push on take, pop on return; a return with nothing taken is ignored.
    always @(posedge sys_clk)
    begin
        ret_pulse <= 1'b0;
        if (!reset_n)
        begin
            stk.delete();
            pc <= 16'h0100;
        end
        else if (core_vec.take)
        begin
            stk.push_back(pc);
            pc <= core_vec.addr;
        end
        else if (ret_req && stk.size() > 0)
        begin
            pc <= stk.pop_back();
            ret_pulse <= 1'b1;
        end
        else
            pc <= pc + 16'h1;
        depth = stk.size();
    end
endmodule
`default_nettype wire

// *** verif/two_level_interrupt_controller_tb_top.sv ***
// Self-checking testbench for the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_controller_tb_top;
    import intc_pkg::*;
    logic sys_clk = 0, reset_n = 0, ret_req = 0, tmr0_overflow = 0;
    logic ret_pulse, waitrequest, wake_req;
    logic [3:0] ext_pin = 4'h0, port_pin = 4'h0;
    logic [23:0] periph_event = 24'h0;
    logic [31:0] readdata, rdv;
    logic [15:0] pc;
    avm_req_s avm = '0;
    core_vec_s core_vec;
    int depth, n_errors = 0, compares = 0, cyc = 0, n, src;

    // ****************************************
    // Clock, instances, timeout
    // ****************************************
    always #25 sys_clk = ~sys_clk;
    two_level_interrupt_controller i_two_level_interrupt_controller(
        .sys_clk(sys_clk), .reset_n(reset_n), .avm(avm),
        .waitrequest(waitrequest), .readdata(readdata),
        .ext_pin(ext_pin), .port_pin(port_pin),
        .tmr0_overflow(tmr0_overflow), .periph_event(periph_event),
        .return_from_interrupt_instr(ret_pulse),
        .core_vec(core_vec), .wake_req(wake_req));
    core_model i_core_model(.sys_clk(sys_clk), .reset_n(reset_n),
        .core_vec(core_vec), .ret_req(ret_req), .ret_pulse(ret_pulse),
        .pc(pc), .depth(depth));
    // A hung handshake would otherwise stall the run forever.
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            report_and_stop;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task report_and_stop;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask
    // The request holds until the rising edge that sees waitrequest low;
    // read data is taken at that edge and only then is the request
    // dropped. Registers are only ever written one by one over the bus.
    task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(posedge sys_clk);
        avm <= '{a, !w, w, {24'h0, d}, 4'hF};
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        rdv = readdata;
        avm.read <= 1'b0;
        avm.write <= 1'b0;
    endtask
    task ev(input logic [24:0] v);
        @(posedge sys_clk);
        {tmr0_overflow, periph_event} <= v;
        @(posedge sys_clk);
        {tmr0_overflow, periph_event} <= 25'h0;
    endtask
    task ret;
        @(posedge sys_clk);
        ret_req <= 1'b1;
        @(posedge sys_clk);
        ret_req <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task wait_take;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (core_vec.take !== 1'b1 && n < 40);
        @(negedge sys_clk);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32973));
        src = $urandom % 24;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        bus(4'hD, 1'b1, 8'($urandom));
        for (int a = 0; a < 16; a++)
        begin
            bus(4'(a), 1'b0, 8'h0);
            chk(rdv, a == 2 ? 32'hFF : a == 3 ? 32'hC0 : 32'h0);
        end
        // Compatibility mode: a low-priority source still uses 0008h.
        ev(25'h1 << src);
        bus(4'(4 + src / 8), 1'b0, 8'h0);
        chk(rdv[src % 8], 1'b1);
        chk(wake_req, 1'b0);
        bus(4'(7 + src / 8), 1'b1, 8'h1 << (src % 8));
        bus(4'(10 + src / 8), 1'b1, 8'h0);
        bus(ADR_INT_CTRL, 1'b1, 8'h80);
        repeat (12) @(posedge sys_clk);
        chk(wake_req, 1'b1);
        chk(depth, 0);
        bus(ADR_INT_CTRL, 1'b1, 8'hC0);
        wait_take;
        chk(pc, VEC_HIGH);
        bus(ADR_INT_CTRL, 1'b0, 8'h0);
        chk(rdv, 32'h40);
        bus(4'(4 + src / 8), 1'b1, 8'h0);
        ret;
        bus(ADR_INT_CTRL, 1'b0, 8'h0);
        chk(rdv, 32'hC0);
        // Priority mode: low service, then timer 0 preempts it.
        bus(ADR_RESET_CTRL, 1'b1, 8'h80);
        bus(ADR_INT_CTRL, 1'b1, 8'hA0);
        ev(25'h1 << src);
        repeat (16) @(posedge sys_clk);
        chk(depth, 0);
        bus(ADR_INT_CTRL, 1'b1, 8'hE0);
        wait_take;
        chk(pc, VEC_LOW);
        ev(25'h1 << 24);
        wait_take;
        chk(pc, VEC_HIGH);
        bus(ADR_INT_CTRL, 1'b0, 8'h0);
        chk(rdv, 32'h24);
        bus(ADR_INT_CTRL, 1'b1, 8'h20);
        ret;
        bus(ADR_INT_CTRL, 1'b0, 8'h0);
        chk(rdv, 32'hA0);
        chk(depth, 1);
        bus(4'(4 + src / 8), 1'b1, 8'h0);
        ret;
        bus(ADR_INT_CTRL, 1'b0, 8'h0);
        chk(rdv, 32'hE0);
        // External pin 0, rising then falling edge selected.
        bus(ADR_INT_CTRL, 1'b1, 8'hD0);
        for (int e = 1; e >= 0; e--)
        begin
            bus(ADR_INT_CTRL_2, 1'b1, e ? 8'hFF : 8'hBF);
            @(posedge sys_clk);
            ext_pin[0] <= 1'(e);
            wait_take;
            chk(n >= 4 && n <= 16, 1'b1);
            chk(pc, VEC_HIGH);
            bus(ADR_INT_CTRL, 1'b1, 8'h50);
            ret;
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
